// ---- design/sscc_activity.sv ----
// Activity and polarity detector for one sync input.
`timescale 1ns/1ps
`include "sscc_regs.svh"
module sscc_activity
  import sscc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sig,
  input wire logic [`SSCC_CNT_W-1:0] interval,
  output logic active_q,
  output logic polarity_q
);
  logic prev_q;
  logic seen_q;
  logic [`SSCC_CNT_W-1:0] tmr_q;
  logic [`SSCC_CNT_W-1:0] hi_q;
  logic [`SSCC_CNT_W-1:0] lo_q;
  logic edge_w;
  logic armed_q;
  // The previous sample is unknown right after reset, so the first cycle
  // counts no edge; an input idling high would otherwise look active.
  assign edge_w = (sig ^ prev_q) & armed_q;

  // Interval timer: flag is set when any edge was seen during a full interval.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      armed_q <= 1'b0;
      seen_q <= 1'b0;
      tmr_q <= '0;
      active_q <= 1'b0;
    end else if (ce) begin
      prev_q <= sig;
      armed_q <= 1'b1;
      if (tmr_q == interval) begin
        tmr_q <= '0;
        active_q <= seen_q | edge_w;
        seen_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q + 1'b1;
        seen_q <= seen_q | edge_w;
      end
    end
  end

  // Polarity: the pulse is the shorter level, so the longer level is idle.
  // A short pulse high means positive-going sync.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_q <= '0;
      lo_q <= '0;
      polarity_q <= 1'b0;
    end else if (ce) begin
      if (tmr_q == interval) begin
        polarity_q <= (hi_q < lo_q);
        hi_q <= '0;
        lo_q <= '0;
      end else if (sig && hi_q != '1) begin
        hi_q <= hi_q + 1'b1;
      end else if (!sig && lo_q != '1) begin
        lo_q <= lo_q + 1'b1;
      end
    end
  end
endmodule

// ---- design/sscc_pkg.sv ----
// Types shared by the sync/clamp block.
package sscc_pkg;
  typedef logic [7:0] sscc_byte_t;
  typedef enum logic [1:0] {
    SSCC_IDLE = 2'b00,
    SSCC_WAIT = 2'b01,
    SSCC_CLAMP = 2'b11
  } sscc_clamp_st_t;
endpackage

// ---- design/sscc_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the sync/clamp block.
`ifndef SSCC_REGS_SVH
`define SSCC_REGS_SVH
// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SSCC_IDX_PRE_HOLD 8'h13
`define SSCC_IDX_POST_HOLD 8'h14
`define SSCC_IDX_ACTIVITY 8'h15
`define SSCC_IDX_POLARITY 8'h16
`define SSCC_IDX_LPF_HIGH 8'h17
`define SSCC_IDX_LPF_LOW 8'h18
`define SSCC_IDX_CLAMP_START 8'h19
`define SSCC_IDX_CLAMP_LEN 8'h1a
`define SSCC_IDX_CLAMP_CTRL 8'h1b
`define SSCC_IDX_SYNC_CTRL 8'h30
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSCC_RST_PRE_HOLD 8'h00
`define SSCC_RST_POST_HOLD 8'h00
`define SSCC_RST_CLAMP_START 8'h08
`define SSCC_RST_CLAMP_LEN 8'h14
`define SSCC_RST_CLAMP_CTRL 8'h00
`define SSCC_RST_SYNC_CTRL 8'h09
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SSCC_CC_RED_MID 7
`define SSCC_CC_GRN_MID 6
`define SSCC_CC_BLU_MID 5
`define SSCC_CC_HOLD_CLAMP 4
`define SSCC_SC_PROC_FILT 0
`define SSCC_SC_FRAME_FILT 1
`define SSCC_SC_HOLD_POL_OVR 2
`define SSCC_SC_HOLD_POL 3
`define SSCC_SC_CHAN_SEL 4
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSCC_CLK_MHZ 100
`define SSCC_DETECT_US 2000
`define SSCC_DETECT_CYC (`SSCC_DETECT_US * `SSCC_CLK_MHZ)
`define SSCC_CNT_W 24
`endif

// ---- design/sscc_top.sv ----
// Sync status, PLL hold window and clamp timing block with APB registers.
// Operation
// - Hold starts pre-hold lines before frame sync
// - Hold extends post-hold lines after frame sync
// - Line-sync activity in status bits 7,6
// - Frame-sync activity in status bits 5,4
// - Green-sync activity in status bits 3,2
// - Clock/hold pin activity in status bit 1
// - Line-sync polarity in bits 7,6
// - Frame-sync polarity in bits 5,4
// - External hold polarity in bit 3
// - Filter lock bit 1, zero means locked
// - Twelve-bit lines-per-frame count, split high/low
// - Clamp starts delay clocks after line sync
// - Clamp lasts programmed length, default 0x14
// - Red clamp ground or midscale
// - Green clamp ground or midscale
// - Blue clamp ground or midscale
// - Clamp suppressed during hold unless enabled
// - Hold polarity automatic unless overridden
// - Processing uses filtered or raw line sync
`timescale 1ns/1ps
`include "sscc_regs.svh"
module sscc_top
  import sscc_pkg::*;
#(
  parameter logic [`SSCC_CNT_W-1:0] DETECT_CYCLES = `SSCC_CNT_W'(`SSCC_DETECT_CYC)
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_sync_in_0,
  input wire logic line_sync_in_1,
  input wire logic frame_sync_in_0,
  input wire logic frame_sync_in_1,
  input wire logic green_sync_slicer_0,
  input wire logic green_sync_slicer_1,
  input wire logic external_pll_hold_in,
  input wire logic filt_line_sync,
  input wire logic filt_frame_sync,
  input wire logic filter_locked,
  output logic pll_hold_q,
  output logic clamp_q,
  output logic red_mid_q,
  output logic green_mid_q,
  output logic blue_mid_q,
  output logic ext_hold_pol_q
);
  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  sscc_byte_t pre_hold_lines_q;
  sscc_byte_t post_hold_lines_q;
  sscc_byte_t clamp_start_delay_q;
  sscc_byte_t clamp_length_q;
  sscc_byte_t clamp_control_q;
  sscc_byte_t sync_control_q;
  logic [11:0] lines_per_frame_q;
  logic [11:0] line_cnt_q;
  logic [6:0] act_w;
  logic [6:0] pol_w;
  logic [6:0] sig_w;
  logic setup_w;
  logic wr_w;
  logic rd_w;
  logic [9:0] idx_w;
  logic hit_w;

  // Byte address to word index.
  function automatic logic [9:0] sscc_index(input logic [11:0] a);
    return a[11:2];
  endfunction

  // Only indices inside the map answer without error; the byte offset bits are not checked.
  function automatic logic sscc_mapped(input logic [9:0] i);
    return (i >= 10'(`SSCC_IDX_PRE_HOLD) && i <= 10'(`SSCC_IDX_CLAMP_CTRL))
        || i == 10'(`SSCC_IDX_SYNC_CTRL);
  endfunction

  assign idx_w = sscc_index(paddr);
  assign hit_w = sscc_mapped(idx_w);
  assign setup_w = psel & ~penable;
  assign wr_w = psel & penable & pready & pwrite & hit_w;
  assign rd_w = setup_w & ~pwrite;

  // --------------------------------------------------------------------------
  // Activity and polarity detectors
  // --------------------------------------------------------------------------
  assign sig_w = {line_sync_in_0, line_sync_in_1, frame_sync_in_0, frame_sync_in_1,
                  green_sync_slicer_0, green_sync_slicer_1, external_pll_hold_in};

  // One detector per watched input; the hold pin is bit 0 of sig_w, the last one listed.
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_det
      sscc_activity u_det (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .sig(sig_w[g]),
        .interval(DETECT_CYCLES),
        .active_q(act_w[g]),
        .polarity_q(pol_w[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // APB slave: one wait-free access phase, error on unmapped index
  // --------------------------------------------------------------------------
  // Ready rises in the access phase, so every transfer takes two cycles.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup_w;
      pslverr <= setup_w & ~hit_w;
    end
  end

  // Read data is captured in the setup cycle and stands through the access.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (ce && rd_w) begin
      prdata <= '0;
      unique case (idx_w)
        10'(`SSCC_IDX_PRE_HOLD): prdata[7:0] <= pre_hold_lines_q;
        10'(`SSCC_IDX_POST_HOLD): prdata[7:0] <= post_hold_lines_q;
        10'(`SSCC_IDX_ACTIVITY): prdata[7:0] <= {act_w, 1'b0};
        10'(`SSCC_IDX_POLARITY): prdata[7:0] <= {pol_w[6:3], ext_hold_pol_q,
                                                 1'b0, ~filter_locked, 1'b0};
        10'(`SSCC_IDX_LPF_HIGH): prdata[7:0] <= {4'h0, lines_per_frame_q[11:8]};
        10'(`SSCC_IDX_LPF_LOW): prdata[7:0] <= lines_per_frame_q[7:0];
        10'(`SSCC_IDX_CLAMP_START): prdata[7:0] <= clamp_start_delay_q;
        10'(`SSCC_IDX_CLAMP_LEN): prdata[7:0] <= clamp_length_q;
        10'(`SSCC_IDX_CLAMP_CTRL): prdata[7:0] <= clamp_control_q;
        10'(`SSCC_IDX_SYNC_CTRL): prdata[7:0] <= sync_control_q;
        default: prdata <= '0;
      endcase
    end
  end

  // Writable registers take effect at the completing access edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_hold_lines_q <= `SSCC_RST_PRE_HOLD;
      post_hold_lines_q <= `SSCC_RST_POST_HOLD;
      clamp_start_delay_q <= `SSCC_RST_CLAMP_START;
      clamp_length_q <= `SSCC_RST_CLAMP_LEN;
      clamp_control_q <= `SSCC_RST_CLAMP_CTRL;
      sync_control_q <= `SSCC_RST_SYNC_CTRL;
    end else if (ce && wr_w) begin
      unique case (idx_w)
        10'(`SSCC_IDX_PRE_HOLD): pre_hold_lines_q <= pwdata[7:0];
        10'(`SSCC_IDX_POST_HOLD): post_hold_lines_q <= pwdata[7:0];
        10'(`SSCC_IDX_CLAMP_START): clamp_start_delay_q <= pwdata[7:0];
        10'(`SSCC_IDX_CLAMP_LEN): clamp_length_q <= pwdata[7:0];
        10'(`SSCC_IDX_CLAMP_CTRL): clamp_control_q <= pwdata[7:0];
        10'(`SSCC_IDX_SYNC_CTRL): sync_control_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Sync source selection and edges
  // --------------------------------------------------------------------------
  logic proc_line_w;
  logic proc_frame_w;
  logic line_prev_q;
  logic frame_prev_q;
  logic line_trail_w;
  logic frame_lead_w;
  logic line_pol_w;
  logic frame_pol_w;
  logic chan_w;
  logic sync_armed_q;

  assign chan_w = sync_control_q[`SSCC_SC_CHAN_SEL];
  assign line_pol_w = chan_w ? pol_w[5] : pol_w[6];
  assign frame_pol_w = chan_w ? pol_w[3] : pol_w[4];
  // Raw inputs are normalised to active-high with their detected polarity.
  // Keeping both filter enables equal is software's duty; mixed settings
  // would skew the hold window by one line.
  assign proc_line_w = sync_control_q[`SSCC_SC_PROC_FILT] ? filt_line_sync :
                       ((chan_w ? line_sync_in_1 : line_sync_in_0) ~^ line_pol_w);
  assign proc_frame_w = sync_control_q[`SSCC_SC_FRAME_FILT] ? filt_frame_sync :
                        ((chan_w ? frame_sync_in_1 : frame_sync_in_0) ~^ frame_pol_w);
  // No edge is taken until the history holds one real sample: a sync that
  // idles high would otherwise fake a frame start right after reset.
  assign line_trail_w = sync_armed_q & line_prev_q & ~proc_line_w;
  assign frame_lead_w = sync_armed_q & ~frame_prev_q & proc_frame_w;

  // Edge history of the processing syncs.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_prev_q <= 1'b0;
      frame_prev_q <= 1'b0;
    end else if (ce) begin
      line_prev_q <= proc_line_w;
      frame_prev_q <= proc_frame_w;
    end
  end

  // Marks that the edge history holds a real sample of the syncs.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_armed_q <= 1'b0;
    end else if (ce) begin
      sync_armed_q <= 1'b1;
    end
  end

  // External hold polarity: detector result or the programmed override.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_hold_pol_q <= 1'b0;
    end else if (ce) begin
      ext_hold_pol_q <= sync_control_q[`SSCC_SC_HOLD_POL_OVR] ?
                        sync_control_q[`SSCC_SC_HOLD_POL] : pol_w[0];
    end
  end

  // --------------------------------------------------------------------------
  // Lines per frame
  // --------------------------------------------------------------------------
  // The count saturates rather than wrapping, so a frame sync returning after 4095 or more lines reads full.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_cnt_q <= '0;
      lines_per_frame_q <= '0;
    end else if (ce) begin
      if (frame_lead_w) begin
        lines_per_frame_q <= line_cnt_q;
        line_cnt_q <= '0;
      end else if (line_trail_w && line_cnt_q != '1) begin
        line_cnt_q <= line_cnt_q + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // PLL hold window
  // --------------------------------------------------------------------------
  // The frame start is predicted from the last frame length, so the window
  // opens pre-hold lines early and closes post-hold lines after frame sync.
  // Until one whole frame was counted there is no prediction, so the first
  // frame after reset gets no early window.
  // Opening at the trailing edge of line (length - pre) leaves pre line periods.
  logic [11:0] open_at_w;
  logic [8:0] post_left_q;
  assign open_at_w = lines_per_frame_q - {4'h0, pre_hold_lines_q};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_hold_q <= 1'b0;
      post_left_q <= '0;
    end else if (ce) begin
      if (frame_lead_w) begin
        post_left_q <= {1'b0, post_hold_lines_q};
        pll_hold_q <= 1'b1;
      end else if (line_trail_w) begin
        if (post_left_q != '0) begin
          post_left_q <= post_left_q - 1'b1;
          pll_hold_q <= 1'b1;
        end else if (pre_hold_lines_q != '0 && lines_per_frame_q > {4'h0, pre_hold_lines_q}
                     && line_cnt_q >= open_at_w) begin
          pll_hold_q <= 1'b1;
        end else begin
          pll_hold_q <= proc_frame_w;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clamp timing
  // --------------------------------------------------------------------------
  sscc_clamp_st_t st_q;
  logic [7:0] ccnt_q;
  logic clamp_ok_w;
  assign clamp_ok_w = ~pll_hold_q | clamp_control_q[`SSCC_CC_HOLD_CLAMP];

  // Delay then pulse; a zero length yields no pulse at all.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SSCC_IDLE;
      ccnt_q <= '0;
      clamp_q <= 1'b0;
    end else if (ce) begin
      unique case (st_q)
        SSCC_IDLE: begin
          clamp_q <= 1'b0;
          if (line_trail_w) begin
            st_q <= SSCC_WAIT;
            ccnt_q <= clamp_start_delay_q;
          end
        end
        SSCC_WAIT: begin
          if (ccnt_q > 8'h01) begin
            ccnt_q <= ccnt_q - 1'b1;
          end else if (clamp_length_q == '0) begin
            st_q <= SSCC_IDLE;
          end else begin
            st_q <= SSCC_CLAMP;
            ccnt_q <= clamp_length_q;
            clamp_q <= clamp_ok_w;
          end
        end
        SSCC_CLAMP: begin
          clamp_q <= clamp_ok_w && ccnt_q > 8'h01;
          if (ccnt_q > 8'h01) begin
            ccnt_q <= ccnt_q - 1'b1;
          end else begin
            st_q <= SSCC_IDLE;
          end
        end
        default: st_q <= SSCC_IDLE;
      endcase
    end
  end

  // Clamp level selects follow the control register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      red_mid_q <= 1'b0;
      green_mid_q <= 1'b0;
      blue_mid_q <= 1'b0;
    end else if (ce) begin
      red_mid_q <= clamp_control_q[`SSCC_CC_RED_MID];
      green_mid_q <= clamp_control_q[`SSCC_CC_GRN_MID];
      blue_mid_q <= clamp_control_q[`SSCC_CC_BLU_MID];
    end
  end
endmodule

// ---- test/sscc_props.sv ----
// Checker of the sync/clamp block's ports.
`timescale 1ns/1ps
`include "sscc_regs.svh"
module sscc_props
  import sscc_pkg::*;
#(
  parameter logic [`SSCC_CNT_W-1:0] DETECT_CYCLES = `SSCC_CNT_W'(`SSCC_DETECT_CYC)
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pll_hold_q,
  input wire logic clamp_q,
  input wire logic red_mid_q,
  input wire logic green_mid_q,
  input wire logic blue_mid_q,
  input wire logic ext_hold_pol_q
);
  logic wr;
  logic mapped;
  logic [7:0] cc_q;
  logic [7:0] sc_q;
  logic [1:0] age_q;
  // Mirrors of the control registers; age counts cycles since a sync-control write.
  assign wr = psel && penable && pready && pwrite && ce;
  assign mapped = paddr[11:10] == 2'b00 && (paddr[9:2] == `SSCC_IDX_SYNC_CTRL ||
    (paddr[9:2] >= `SSCC_IDX_PRE_HOLD && paddr[9:2] <= `SSCC_IDX_CLAMP_CTRL));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_q <= `SSCC_RST_CLAMP_CTRL;
      sc_q <= `SSCC_RST_SYNC_CTRL;
      age_q <= 2'd0;
    end else begin
      if (wr && paddr == {2'b00, `SSCC_IDX_CLAMP_CTRL, 2'b00}) begin
        cc_q <= pwdata[7:0];
      end
      if (wr && paddr == {2'b00, `SSCC_IDX_SYNC_CTRL, 2'b00}) begin
        sc_q <= pwdata[7:0];
        age_q <= 2'd0;
      end else if (age_q != 2'd3) begin
        age_q <= age_q + 2'd1;
      end
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_after_setup_a: assert property (psel && !penable && ce |=> pready)
    else $error("no pready after setup");
  ready_needs_setup_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  slverr_decode_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
    else $error("pslverr decode wrong");
  read_upper_zero_a: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h00_0000 && (!pslverr || prdata[7:0] == 8'h00)) else $error("bad rdata");
  mid_select_a: assert property (
    $stable(cc_q[7:5]) |-> {red_mid_q, green_mid_q, blue_mid_q} == cc_q[7:5])
    else $error("mid select wrong");
  clamp_hold_block_a: assert property (
    !cc_q[4] && pll_hold_q && $past(pll_hold_q) && $past(pll_hold_q, 2) |-> !$rose(clamp_q))
    else $error("clamp during hold");
  hold_pol_force_a: assert property (
    age_q == 2'd3 && sc_q[2] |-> ext_hold_pol_q == sc_q[3]) else $error("hold polarity");
  cover property (wr && paddr == {2'b00, `SSCC_IDX_CLAMP_CTRL, 2'b00});
  cover property ($rose(clamp_q));
  cover property ($rose(pll_hold_q));
endmodule
bind sscc_top sscc_props #(.DETECT_CYCLES(DETECT_CYCLES)) sscc_props_inst (.clk, .rst_b, .ce,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pll_hold_q, .clamp_q,
  .red_mid_q, .green_mid_q, .blue_mid_q, .ext_hold_pol_q);

// ---- test/sscc_video_src.sv ----
// Behavioural video source driving raw sync pins and the filter's regenerated syncs.
`timescale 1ns/1ps
module sscc_video_src #(
  parameter int LINE = 64
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] act,
  input wire logic [4:0] pol,
  input wire logic [11:0] lines,
  output logic [6:0] pins,
  output logic filt_line,
  output logic filt_frame
);
  logic [7:0] pix_q;
  logic [11:0] ln_q;
  // Pixel and line counters; pulses stay narrow so high time is below low time.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pix_q <= 8'h00;
      ln_q <= 12'h000;
    end else if (pix_q == 8'(LINE - 1)) begin
      pix_q <= 8'h00;
      ln_q <= (ln_q + 12'h001 >= lines) ? 12'h000 : ln_q + 12'h001;
    end else begin
      pix_q <= pix_q + 8'h01;
    end
  end
  // Filtered syncs are active high; a quiet pin parks at its idle level.
  assign filt_line = pix_q < 8'h04;
  assign filt_frame = ln_q == 12'h000;
  assign pins[0] = act[0] ? filt_line ~^ pol[0] : !pol[0];
  assign pins[1] = act[1] ? filt_line ~^ pol[1] : !pol[1];
  assign pins[2] = act[2] ? filt_frame ~^ pol[2] : !pol[2];
  assign pins[3] = act[3] ? filt_frame ~^ pol[3] : !pol[3];
  assign pins[4] = act[4] ? !filt_line : 1'b1;
  assign pins[5] = act[5] ? !filt_line : 1'b1;
  assign pins[6] = act[6] ? filt_frame ~^ pol[4] : !pol[4];
endmodule

// ---- test/testbench.sv ----
// Self-checking testbench of the sync/clamp block.
`timescale 1ns/1ps
`include "sscc_regs.svh"
module testbench;
  import sscc_pkg::*;
  localparam int LINE = 64;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, locked = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, fl, ff, hold, clamp, ext_pol;
  logic fl_q = 1'b0, ff_q = 1'b0, hold_q = 1'b0, cl_q = 1'b0;
  logic [6:0] act = 7'h7f;
  logic [6:0] pins;
  logic [4:0] pol = 5'h00;
  logic [11:0] lines = 12'h010;
  logic [2:0] mid;
  int failures = 0;
  int tests_run = 0;
  int cyc, t_fall, t_rise, t_hold, dly, wid, pre_n, post_n, post_c, nrise, cih;
  logic [7:0] rw_idx [5] = '{`SSCC_IDX_PRE_HOLD, `SSCC_IDX_POST_HOLD, `SSCC_IDX_CLAMP_START,
    `SSCC_IDX_CLAMP_LEN, `SSCC_IDX_CLAMP_CTRL};
  logic [7:0] rw_rst [5] = '{`SSCC_RST_PRE_HOLD, `SSCC_RST_POST_HOLD, `SSCC_RST_CLAMP_START,
    `SSCC_RST_CLAMP_LEN, `SSCC_RST_CLAMP_CTRL};
  sscc_top #(.DETECT_CYCLES(24'h07d0)) sscc_top_inst (.clk, .rst_b, .ce(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_sync_in_0(pins[0]),
    .line_sync_in_1(pins[1]), .frame_sync_in_0(pins[2]), .frame_sync_in_1(pins[3]),
    .green_sync_slicer_0(pins[4]), .green_sync_slicer_1(pins[5]), .external_pll_hold_in(pins[6]),
    .filt_line_sync(fl), .filt_frame_sync(ff), .filter_locked(locked), .pll_hold_q(hold),
    .clamp_q(clamp), .red_mid_q(mid[2]), .green_mid_q(mid[1]), .blue_mid_q(mid[0]),
    .ext_hold_pol_q(ext_pol));
  sscc_video_src #(.LINE(LINE)) sscc_video_src_inst (.clk, .rst_b, .act, .pol, .lines, .pins,
    .filt_line(fl), .filt_frame(ff));
  always #5 clk = ~clk;
  // Cycle count; the sequence needs about 30000 cycles, so a hang stops at 40000.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      finish_test();
    end
  end
  // Clamp and hold edges timed against the filtered syncs, sampled as the block sees them.
  always @(posedge clk) begin
    {fl_q, ff_q, hold_q, cl_q} <= {fl, ff, hold, clamp};
    if (fl_q && !fl) begin
      t_fall <= cyc;
      post_c <= post_c + hold;
    end
    if (!cl_q && clamp) begin
      {dly, t_rise, nrise, cih} <= {cyc - t_fall, cyc, nrise + 1, cih + hold};
    end
    if (cl_q && !clamp) wid <= cyc - t_rise;
    if (!hold_q && hold) t_hold <= cyc;
    if (hold_q && !hold) post_n <= post_c;
    if (!ff_q && ff) begin
      pre_n <= (cyc - t_hold + LINE / 2) / LINE;
      post_c <= 0;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 2'b00, idx, 2'b00, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  function automatic logic near(input int seen, input int exp, input int lo, input int hi);
    return seen >= exp - lo && seen <= exp + hi;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] v;
    int d;
    int len;
    void'($urandom(32'h8e27));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      apb(1'b0, rw_idx[i], 32'h0000_0000);
      check("reset value", rd, 32'(rw_rst[i]));
      apb(1'b1, rw_idx[i], {24'h00_0000, v});
      apb(1'b0, rw_idx[i], 32'h0000_0000);
      check("read back", rd, 32'(v));
    end
    apb(1'b0, `SSCC_IDX_SYNC_CTRL, 32'h0000_0000);
    check("sync control reset", rd, 32'(`SSCC_RST_SYNC_CTRL));
    apb(1'b1, 8'h20, 32'hffff_ffff);
    check("unmapped write error", err, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped read", {rd[30:0], err}, 32'h0000_0001);
    $display("test registers done");
    // Filter enables stay equal; the first pass runs raw syncs on channel 1.
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `SSCC_IDX_SYNC_CTRL, (k == 0) ? 32'h0000_0010 : 32'h0000_0003);
      {act, pol, locked} <= {(k == 0) ? 7'h7f : 7'($urandom), 5'($urandom), 1'($urandom)};
      lines <= 12'(12 + $urandom % 9);
      repeat (4500) @(posedge clk);
      v = {act[0], act[1], act[2], act[3], act[6], 3'h7};
      apb(1'b0, `SSCC_IDX_ACTIVITY, 32'h0000_0000);
      check("activity", rd, {24'h00_0000, act[0], act[1], act[2], act[3], act[4], act[5],
        act[6], 1'b0});
      apb(1'b0, `SSCC_IDX_POLARITY, 32'h0000_0000);
      check("polarity", rd[7:0] & v,
        {pol[0], pol[1], pol[2], pol[3], pol[4], 1'b0, !locked, 1'b0} & v);
      apb(1'b0, `SSCC_IDX_LPF_HIGH, 32'h0000_0000);
      check("lines high", rd, 32'(lines[11:8]));
      apb(1'b0, `SSCC_IDX_LPF_LOW, 32'h0000_0000);
      check("lines low", rd, 32'(lines[7:0]));
      if (act[6]) check("auto hold polarity", ext_pol, 32'(pol[4]));
    end
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `SSCC_IDX_SYNC_CTRL, 32'(8'h07 | (p << 3)));
      repeat (4) @(posedge clk);
      check("forced hold polarity", ext_pol, 32'(p));
    end
    apb(1'b1, `SSCC_IDX_SYNC_CTRL, 32'h0000_0003);
    $display("test status done");
    {act, lines} <= {7'h7f, 12'h010};
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 0 : 1 + $urandom % 20;
      len = (k == 1) ? 0 : 1 + $urandom % 30;
      v = {3'($urandom), 5'h10};
      apb(1'b1, `SSCC_IDX_CLAMP_CTRL, 32'(v));
      apb(1'b1, `SSCC_IDX_CLAMP_START, 32'(d));
      apb(1'b1, `SSCC_IDX_CLAMP_LEN, 32'(len));
      repeat (LINE) @(posedge clk);
      nrise = 0;
      repeat (3 * LINE) @(posedge clk);
      check("mid select", mid, 32'(v[7:5]));
      check("clamp seen", nrise > 0, len > 0);
      check("clamp delay", near(dly, (d > 1 ? d : 1) + 1, 1, 2) || len == 0, 1);
      check("clamp width", near(wid, len, 1, 1) || len == 0, 1);
    end
    $display("test clamp done");
    apb(1'b1, `SSCC_IDX_CLAMP_START, 32'h0000_0004);
    apb(1'b1, `SSCC_IDX_CLAMP_LEN, 32'h0000_000a);
    for (int k = 0; k < 2; k++) begin
      {d, len} = {1 + $urandom % 3, 1 + $urandom % 3};
      apb(1'b1, `SSCC_IDX_PRE_HOLD, 32'(d));
      apb(1'b1, `SSCC_IDX_POST_HOLD, 32'(len));
      apb(1'b1, `SSCC_IDX_CLAMP_CTRL, 32'(k << 4));
      repeat (2100) @(posedge clk);
      cih = 0;
      repeat (2100) @(posedge clk);
      check("pre-hold lines", near(pre_n, d, 1, 1), 1);
      check("post-hold lines", near(post_n, len, 1, 1), 1);
      check("clamp in hold", cih > 0, k);
    end
    $display("test hold done");
    finish_test();
  end
endmodule
